// [rms_status_reg.sv]
// reverse-mode status and bus fault interrupt mask register
`timescale 1ns/10ps
`include "rms_defs.svh"

module rms_status_reg
	import rms_pkg::*;
#(
	parameter int CUR_W = 8
)
(
	input wire logic ref_clk_i, // core clock, 200 MHz
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic [7:0] reg_addr_i, // register address from bus slave
	input wire logic reg_wr_i, // one-cycle write strobe
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic reg_rd_i, // one-cycle read strobe
	output logic [7:0] reg_rdata_o, // register image
	input wire logic bus_fault_i, // one-cycle pulse: command or bus fault
	input wire logic reverse_mode_i, // async level: reverse mode running
	input wire logic batt_cutoff_cmp_i, // async comparator: battery below cutoff
	input wire logic batt_ov_cmp_i, // async comparator: battery above overvoltage
	input wire logic [CUR_W-1:0] batt_sense_current_i, // current across batt sense pins
	input wire logic [CUR_W-1:0] reverse_batt_current_limit_i, // battery limit setting
	input wire logic [CUR_W-1:0] input_sense_current_i, // current across input sense pins
	input wire logic [CUR_W-1:0] reverse_out_current_limit_i, // output limit setting
	input wire logic [2:0] reverse_state_i, // state from reverse-mode controller
	output logic interrupt_pin_n_o // interrupt pin, active low
);

	// the comparators are plain unsigned compares; wider codes are not served
	if (CUR_W < 1 || CUR_W > 16)
	begin : g_bad_cur_w
		$error("rms_status_reg: CUR_W must be 1 to 16");
	end

	localparam int NS = `RMS_SYNC_STAGES;

	typedef struct packed {
		logic [NS-1:0] act_s;
		logic [NS-1:0] cut_s;
		logic [NS-1:0] ov_s;
		logic act;
		logic cut;
		logic ov;
		logic mask;
		logic pend;
		logic [7:0] rdata;
		logic pin_n;
	} rms_reg_t;

	rms_reg_t q;
	rms_reg_t d;

	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr == `RMS_REG_ADDR);
	endfunction : reg_hit

	// invalid or idle codes collapse to reset so the host never sees 101..111
	function automatic logic [2:0] clean_state(input logic act, input logic [2:0] raw);
		rms_state_t s;
		s = reverse_state_reset;
		if (act)
		begin
			case (raw)
				`RMS_CODE_SOFTSTART: s = reverse_state_softstart;
				`RMS_CODE_REGULATING: s = reverse_state_regulating;
				`RMS_CODE_HICCUP: s = reverse_state_hiccup;
				`RMS_CODE_LIGHTLOAD_OFF: s = reverse_state_lightload_off;
				default: s = reverse_state_reset;
			endcase
		end
		clean_state = s;
	endfunction : clean_state

	always_comb
	begin
		d = q;
		// three-stage synchronisers for the analog levels
		d.act_s = {q.act_s[NS-2:0], reverse_mode_i};
		d.cut_s = {q.cut_s[NS-2:0], batt_cutoff_cmp_i};
		d.ov_s = {q.ov_s[NS-2:0], batt_ov_cmp_i};
		// a level counts only once stages two and three agree
		if (q.act_s[1] == q.act_s[2])
			d.act = q.act_s[2];
		if (q.cut_s[1] == q.cut_s[2])
			d.cut = q.cut_s[2];
		if (q.ov_s[1] == q.ov_s[2])
			d.ov = q.ov_s[2];
		if (reg_wr_i && reg_hit(reg_addr_i))
			d.mask = reg_wdata_i[`RMS_BIT_FAULT_MASK];
		// pending fault cleared by a read; a fault in the same cycle wins
		if (reg_rd_i && reg_hit(reg_addr_i))
			d.pend = 1'b0;
		if (bus_fault_i)
			d.pend = 1'b1;
		d.pin_n = ~(d.pend & ~d.mask);
		d.rdata = `RMS_REG_RESET;
		d.rdata[`RMS_BIT_FAULT_MASK] = d.mask;
		// status bits are live, not latched, and only meaningful in reverse mode
		d.rdata[`RMS_BIT_BATT_CC] = q.act
			&& (batt_sense_current_i >= reverse_batt_current_limit_i);
		d.rdata[`RMS_BIT_OUT_CC] = q.act
			&& (input_sense_current_i >= reverse_out_current_limit_i);
		d.rdata[`RMS_BIT_CUTOFF] = q.act && q.cut;
		d.rdata[`RMS_BIT_OVERVOLT] = q.act && q.ov;
		d.rdata[`RMS_STATE_MSB:`RMS_STATE_LSB] = clean_state(q.act, reverse_state_i);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			q <= '0;
			q.pin_n <= `RMS_PIN_IDLE;
		end
		else
		begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign interrupt_pin_n_o = q.pin_n;

	a_mask_blocks_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rdata_o[`RMS_BIT_FAULT_MASK] |-> interrupt_pin_n_o)
		else $error("masked bus fault reached the interrupt pin");

	a_fault_drives_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		bus_fault_i && !q.mask && !reg_wr_i |=> !interrupt_pin_n_o)
		else $error("unmasked bus fault did not pull the interrupt pin low");

	a_batt_cc_live: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.act && (batt_sense_current_i >= reverse_batt_current_limit_i)
		|=> reg_rdata_o[`RMS_BIT_BATT_CC])
		else $error("battery-side current flag missing at limit");

	a_batt_cc_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		batt_sense_current_i < reverse_batt_current_limit_i |=> !reg_rdata_o[`RMS_BIT_BATT_CC])
		else $error("battery-side current flag set below limit");

	a_out_cc_live: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		##1 reg_rdata_o[`RMS_BIT_OUT_CC]
		== ($past(q.act) && ($past(input_sense_current_i) >= $past(reverse_out_current_limit_i))))
		else $error("output-side current flag wrong");

	a_batt_levels: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.act |=> reg_rdata_o[`RMS_BIT_CUTOFF] == $past(q.cut)
		&& reg_rdata_o[`RMS_BIT_OVERVOLT] == $past(q.ov))
		else $error("battery level flags do not follow the filtered comparators");

	a_state_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.act && reverse_state_i == `RMS_CODE_HICCUP |=> reg_rdata_o[2:0] == `RMS_CODE_HICCUP)
		else $error("state code not passed through");

	a_idle_state_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!q.act |=> reg_rdata_o[6:0] == 7'h00)
		else $error("status nonzero outside reverse mode");

	a_no_bad_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rdata_o[2:0] <= `RMS_CODE_LIGHTLOAD_OFF)
		else $error("invalid state code reported");

	a_write_mask_only: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_hit(reg_addr_i) && !q.act
		|=> reg_rdata_o == {$past(reg_wdata_i[7]), 7'h00})
		else $error("write reached a status bit");

	a_reset_zero: assert property (@(posedge ref_clk_i)
		!rst_b_i |=> reg_rdata_o == `RMS_REG_RESET && interrupt_pin_n_o)
		else $error("register not zero after reset");

	a_read_clears_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rd_i && reg_hit(reg_addr_i) && !bus_fault_i |=> interrupt_pin_n_o)
		else $error("read of the register did not release the interrupt pin");

	a_pin_stays_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!interrupt_pin_n_o && !reg_rd_i && !reg_wr_i |=> !interrupt_pin_n_o)
		else $error("pending bus fault dropped without a read");

	a_pin_needs_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		interrupt_pin_n_o && !bus_fault_i && !reg_wr_i |=> interrupt_pin_n_o)
		else $error("interrupt pin fell without a bus fault");

	a_out_cc_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		input_sense_current_i < reverse_out_current_limit_i |=> !reg_rdata_o[`RMS_BIT_OUT_CC])
		else $error("output-side current flag set below limit");

	a_lightload_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.act && reverse_state_i == `RMS_CODE_LIGHTLOAD_OFF
		|=> reg_rdata_o[`RMS_STATE_MSB:`RMS_STATE_LSB] == `RMS_CODE_LIGHTLOAD_OFF)
		else $error("light-load state code not passed through");

	a_bad_code_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reverse_state_i > `RMS_CODE_LIGHTLOAD_OFF
		|=> reg_rdata_o[`RMS_STATE_MSB:`RMS_STATE_LSB] == `RMS_CODE_RESET)
		else $error("invalid controller code not shown as reset");

	a_mask_written: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_hit(reg_addr_i)
		|=> reg_rdata_o[`RMS_BIT_FAULT_MASK] == $past(reg_wdata_i[`RMS_BIT_FAULT_MASK]))
		else $error("mask bit did not take the written value");

	a_mask_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!(reg_wr_i && reg_hit(reg_addr_i)) |=> $stable(reg_rdata_o[`RMS_BIT_FAULT_MASK]))
		else $error("mask bit changed without a write to the register");

	a_act_filter: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.act_s[1] != q.act_s[2] |=> $stable(q.act))
		else $error("reverse-mode level taken before its stages agreed");

	a_cut_filter: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.cut_s[1] != q.cut_s[2] |=> $stable(q.cut))
		else $error("cutoff level taken before its stages agreed");

	a_ov_filter: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		q.ov_s[1] != q.ov_s[2] |=> $stable(q.ov))
		else $error("overvoltage level taken before its stages agreed");

endmodule : rms_status_reg

// [rms_defs.svh]
// register address, field positions, reset values and state codes of the reverse-mode status register
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

`define RMS_REG_ADDR 8'h20
`define RMS_REG_RESET 8'h00
`define RMS_BIT_FAULT_MASK 7
`define RMS_BIT_BATT_CC 6
`define RMS_BIT_OUT_CC 5
`define RMS_BIT_CUTOFF 4
`define RMS_BIT_OVERVOLT 3
`define RMS_STATE_MSB 2
`define RMS_STATE_LSB 0
`define RMS_CODE_RESET 3'h0
`define RMS_CODE_SOFTSTART 3'h1
`define RMS_CODE_REGULATING 3'h2
`define RMS_CODE_HICCUP 3'h3
`define RMS_CODE_LIGHTLOAD_OFF 3'h4
`define RMS_SYNC_STAGES 3
`define RMS_PIN_IDLE 1'h1

`endif

// [rms_pkg.sv]
// types shared by the reverse-mode status register
`include "rms_defs.svh"

package rms_pkg;

	typedef enum logic [2:0]
	{
		reverse_state_reset = 3'b000,
		reverse_state_softstart = 3'b001,
		reverse_state_regulating = 3'b010,
		reverse_state_hiccup = 3'b011,
		reverse_state_lightload_off = 3'b100
	} rms_state_t;

endpackage : rms_pkg

// [rms_host_model.sv]
// host-side access model for the reverse-mode status register
`timescale 1ns/10ps
module rms_host_model
(
	input wire logic ref_clk_i, // core clock
	output logic [7:0] reg_addr_o, // register address
	output logic reg_wr_o, // write strobe
	output logic [7:0] reg_wdata_o, // write data
	output logic reg_rd_o, // read strobe
	input wire logic [7:0] reg_rdata_i // register image
);
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'h0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'h0;
	end
	// released address and data lines show the inverse and both strobes drop low, so a stale address never looks valid
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk_i);
		#1;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge ref_clk_i);
		q = reg_rdata_i;
		#1;
		reg_wr_o = 1'h0;
		reg_rd_o = 1'h0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : access
endmodule : rms_host_model

// [tb_top.sv]
// testbench for the reverse-mode status register
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
	logic ref_clk_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic [7:0] addr, wdata, rdata, q;
	logic wr, rd, pin_n, fault = 1'h0, rev = 1'h0, cut = 1'h0, ov = 1'h0;
	logic [7:0] bs = 8'h00, bl = 8'h80, is = 8'h00, ol = 8'h80;
	logic [2:0] st = 3'h0;
	int err_count = 0;
	int n_checks = 0;
	rms_status_reg rms_status_reg_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .bus_fault_i(fault), .reverse_mode_i(rev),
		.batt_cutoff_cmp_i(cut), .batt_ov_cmp_i(ov), .batt_sense_current_i(bs),
		.reverse_batt_current_limit_i(bl), .input_sense_current_i(is),
		.reverse_out_current_limit_i(ol), .reverse_state_i(st), .interrupt_pin_n_o(pin_n));
	rms_host_model rms_host_model_i (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
		.reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));
	initial
	begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic rd_chk(input logic [7:0] ex);
		rms_host_model_i.access(1'h0, 8'h20, 8'h00, q);
		`CHK("status", ex, q)
	endtask : rd_chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		rms_host_model_i.access(1'h1, a, d, q);
	endtask : wr_reg
	task automatic pulse_fault;
		fault = 1'h1;
		tick(1);
		fault = 1'h0;
		tick(1);
	endtask : pulse_fault
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		wrap_up();
	end
	initial
	begin
		tick(8);
		rst_b_i = 1'h1;
		`CHK("pin", 1'h1, pin_n)
		rd_chk(8'h00);
		pulse_fault();
		`CHK("pin", 1'h0, pin_n)
		rd_chk(8'h00);
		tick(1);
		`CHK("pin", 1'h1, pin_n)
		wr_reg(8'h20, 8'hFF);
		rd_chk(8'h80);
		wr_reg(8'h21, 8'h00);
		rd_chk(8'h80);
		pulse_fault();
		tick(1);
		`CHK("pin", 1'h1, pin_n)
		wr_reg(8'h20, 8'h00);
		tick(1);
		`CHK("pin", 1'h0, pin_n)
		rd_chk(8'h00);
		tick(1);
		`CHK("pin", 1'h1, pin_n)
		// each limit sits exactly at its sensed code in one of the two reads to catch a strict compare
		rev = 1'h1;
		bs = 8'h80;
		is = 8'h7F;
		cut = 1'h1;
		st = 3'h2;
		tick(6);
		rd_chk(8'h52);
		bs = 8'h7F;
		is = 8'h80;
		cut = 1'h0;
		ov = 1'h1;
		tick(6);
		rd_chk(8'h2A);
		for (int i = 0; i < 8; i++)
		begin
			st = 3'(i);
			tick(2);
			rd_chk({5'h05, (i < 5) ? 3'(i) : 3'h0});
		end
		// move both limits so a compare against a fixed code is caught
		bl = 8'h7F;
		ol = 8'h81;
		tick(2);
		rd_chk(8'h48);
		rev = 1'h0;
		st = 3'h2;
		tick(6);
		rd_chk(8'h00);
		wrap_up();
	end
endmodule : tb_top
